/* File: src/scb_pkg.sv */
// Package: register map, field positions and constants of the stop/collision/baud block
package scb_pkg;
  // ********************************
  // Register indices
  // ********************************
  localparam logic [2:0] ADDR_BAUD_RELOAD = 3'h0;
  localparam logic [2:0] ADDR_SHIFT_BUF = 3'h1;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h4;
  localparam logic [2:0] ADDR_ADDR_MASK = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;
  // ********************************
  // Field positions
  // ********************************
  localparam int CTRL1_EN_BIT = 5;
  localparam int CTRL1_WCOL_BIT = 7;
  localparam int CTRL2_STOP_BIT = 2;
  localparam int STAT_STOP_SEEN_BIT = 4;
  localparam int FLAG_COLL_BIT = 0;
  localparam int FLAG_EVENT_BIT = 1;
  // ********************************
  // Modes and resets
  // ********************************
  localparam logic [3:0] MODE_SPI_BRG = 4'hA;
  localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] SPI_BITS_LAST = 3'h7;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SDA_LOW = 3'b001,
    ST_SCL_REL = 3'b010,
    ST_SCL_HIGH = 3'b011,
    ST_SDA_REL = 3'b100,
    ST_DONE = 3'b101,
    ST_SPI = 3'b110
  } scb_state_t;
endpackage : scb_pkg

/* File: src/scb_top.sv */
// I2C master stop sequencing, stop-time collision detection and shared baud counter
`timescale 1ns/1ps
module scb_top
  import scb_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // I2C bus pins
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // SPI clock pin
  output logic spi_sck
);

  // ********************************
  // Registers
  // ********************************
  logic [7:0] reload_reg, reload_next;
  logic [7:0] buf_reg, buf_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] ctrl3_reg, ctrl3_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] stat_reg, stat_next;
  logic coll_reg, coll_next;
  logic event_reg, event_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  scb_state_t state_reg, state_next;
  logic sda_oe_reg, sda_oe_next;
  logic scl_oe_reg, scl_oe_next;
  logic sck_reg, sck_next;
  logic [3:0] edges_reg, edges_next;
  logic tick_reg, tick_next;

  logic enabled;
  logic i2c_mode;
  logic spi_mode;
  logic expired;
  logic wr_hit;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction : hit

  assign enabled = ctrl1_reg[CTRL1_EN_BIT];
  assign i2c_mode = enabled && (ctrl1_reg[3:0] == MODE_I2C_MASTER);
  assign spi_mode = enabled && (ctrl1_reg[3:0] == MODE_SPI_BRG);
  assign expired = (cnt_reg == '0) && tick_reg;

  // ********************************
  // Register file and stop sequencer
  // ********************************
  always_comb
  begin
    reload_next = reload_reg;
    buf_next = buf_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ctrl3_next = ctrl3_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    coll_next = coll_reg;
    event_next = event_reg;
    rdata_next = RESET_BYTE;
    cnt_next = cnt_reg;
    state_next = state_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = scl_oe_reg;
    sck_next = sck_reg;
    edges_next = edges_reg;
    tick_next = ~tick_reg;
    wr_hit = 1'b0;

    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_BAUD_RELOAD: rdata_next = reload_reg;
        ADDR_SHIFT_BUF: rdata_next = buf_reg;
        ADDR_CTRL_ONE: rdata_next = ctrl1_reg;
        ADDR_CTRL_TWO: rdata_next = ctrl2_reg;
        ADDR_CTRL_THREE: rdata_next = ctrl3_reg;
        ADDR_ADDR_MASK: rdata_next = mask_reg;
        ADDR_STATUS: rdata_next = stat_reg;
        ADDR_FLAGS: rdata_next = {6'h00, event_reg, coll_reg};
        default: rdata_next = RESET_BYTE;
      endcase
    end

    if (reg_wr)
    begin
      if (hit(reg_addr, ADDR_BAUD_RELOAD))
        reload_next = reg_wdata;
      if (hit(reg_addr, ADDR_CTRL_ONE))
        ctrl1_next = reg_wdata;
      if (hit(reg_addr, ADDR_CTRL_TWO))
        ctrl2_next = reg_wdata;
      if (hit(reg_addr, ADDR_CTRL_THREE))
        ctrl3_next = reg_wdata;
      if (hit(reg_addr, ADDR_ADDR_MASK))
        mask_next = reg_wdata;
      if (hit(reg_addr, ADDR_FLAGS))
      begin
        // Write one to clear; hardware set below wins
        coll_next = coll_reg & ~reg_wdata[FLAG_COLL_BIT];
        event_next = event_reg & ~reg_wdata[FLAG_EVENT_BIT];
      end
      if (hit(reg_addr, ADDR_SHIFT_BUF))
      begin
        // Buffer is locked while a sequence runs
        if (state_reg != ST_IDLE)
          ctrl1_next[CTRL1_WCOL_BIT] = 1'b1;
        else
        begin
          buf_next = reg_wdata;
          wr_hit = 1'b1;
        end
      end
    end

    case (state_reg)
      ST_IDLE:
      begin
        if (i2c_mode && ctrl2_next[CTRL2_STOP_BIT])
        begin
          sda_oe_next = 1'b1;
          stat_next[STAT_STOP_SEEN_BIT] = 1'b0;
          state_next = ST_SDA_LOW;
        end
        else if (spi_mode && wr_hit)
        begin
          cnt_next = reload_reg;
          edges_next = '0;
          state_next = ST_SPI;
        end
      end
      ST_SDA_LOW:
      begin
        if (!sda_in)
        begin
          scl_oe_next = 1'b0;
          state_next = ST_SCL_REL;
        end
      end
      ST_SCL_REL:
      begin
        if (scl_in)
        begin
          cnt_next = reload_reg;
          state_next = ST_SCL_HIGH;
        end
      end
      ST_SCL_HIGH:
      begin
        if (!scl_in)
          state_next = ST_IDLE;
        else if (expired)
        begin
          sda_oe_next = 1'b0;
          cnt_next = reload_reg;
          state_next = ST_SDA_REL;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_SDA_REL:
      begin
        if (!scl_in && !sda_in)
          state_next = ST_IDLE;
        else if (expired)
        begin
          if (!sda_in)
            state_next = ST_IDLE;
          else
          begin
            stat_next[STAT_STOP_SEEN_BIT] = 1'b1;
            cnt_next = reload_reg;
            state_next = ST_DONE;
          end
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_DONE:
      begin
        if (expired)
        begin
          ctrl2_next[CTRL2_STOP_BIT] = 1'b0;
          event_next = 1'b1;
          state_next = ST_IDLE;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_SPI:
      begin
        // Two rollovers per SPI clock period
        if (!spi_mode)
          state_next = ST_IDLE;
        else if (expired)
        begin
          sck_next = ~sck_reg;
          cnt_next = reload_reg;
          edges_next = edges_reg + 4'h1;
          if (edges_reg == {SPI_BITS_LAST, 1'b1})
            state_next = ST_IDLE;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default: state_next = ST_IDLE;
    endcase

    // Counter steps every second clock, so one rollover is 2*(reload+1) clocks
    if (!tick_reg && state_reg != ST_IDLE && state_reg != ST_SCL_REL)
      cnt_next = cnt_reg;
    // Phase starts fresh at every first load
    if (state_reg == ST_IDLE || state_reg == ST_SCL_REL)
      tick_next = 1'b0;

    // Any collision in a stop: flag, release lines, drop request
    if ((state_reg == ST_SCL_HIGH && !scl_in)
      || (state_reg == ST_SDA_REL && ((!scl_in && !sda_in) || (expired && !sda_in))))
    begin
      coll_next = 1'b1;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      ctrl2_next[CTRL2_STOP_BIT] = 1'b0;
    end

    if (!enabled)
    begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      stat_next[STAT_STOP_SEEN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reload_reg <= RESET_BYTE;
      buf_reg <= RESET_BYTE;
      ctrl1_reg <= RESET_BYTE;
      ctrl2_reg <= RESET_BYTE;
      ctrl3_reg <= RESET_BYTE;
      mask_reg <= RESET_BYTE;
      stat_reg <= RESET_BYTE;
      coll_reg <= 1'b0;
      event_reg <= 1'b0;
      rdata_reg <= RESET_BYTE;
      cnt_reg <= '0;
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sck_reg <= 1'b0;
      edges_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      reload_reg <= reload_next;
      buf_reg <= buf_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ctrl3_reg <= ctrl3_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      coll_reg <= coll_next;
      event_reg <= event_next;
      rdata_reg <= rdata_next;
      cnt_reg <= cnt_next;
      state_reg <= state_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      sck_reg <= sck_next;
      edges_reg <= edges_next;
      tick_reg <= tick_next;
    end
  end

  // Open drain: only ever drive low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign scl_oe = scl_oe_reg;
  assign spi_sck = sck_reg;
  assign reg_rdata = rdata_reg;

  // ********************************
  // Assertions
  // ********************************
  sequence s_scl_loaded;
    state_reg == ST_SCL_REL && scl_in;
  endsequence

  property p_scl_release;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_SDA_LOW && !sda_in && enabled) |=> !scl_oe && sda_oe && state_reg == ST_SCL_REL;
  endproperty
  a_scl_release: assert property (p_scl_release) else $error("SCL not released");

  property p_load;
    @(posedge clk) disable iff (!rstn)
      (s_scl_loaded and enabled) |=> cnt_reg == $past(reload_reg);
  endproperty
  a_load: assert property (p_load) else $error("Counter not loaded");

  property p_coll3;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_SDA_REL && expired && !sda_in && enabled) |=> coll_reg && state_reg == ST_IDLE;
  endproperty
  a_coll3: assert property (p_coll3) else $error("Missed SDA collision");

  property p_coll4;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_SCL_HIGH && !scl_in) |=> coll_reg && !sda_oe && !scl_oe;
  endproperty
  a_coll4: assert property (p_coll4) else $error("Missed SCL collision");

  property p_start;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_IDLE && spi_mode && reg_wr && reg_addr == ADDR_SHIFT_BUF && !ctrl2_reg[CTRL2_STOP_BIT]
        && !(i2c_mode)) |=> state_reg == ST_SPI && cnt_reg == $past(reload_reg);
  endproperty
  a_start: assert property (p_start) else $error("Buffer write did not start counter");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_IDLE) |=> spi_sck == $past(spi_sck);
  endproperty
  a_hold: assert property (p_hold) else $error("Clock pin moved while idle");

  property p_toggle;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_SPI && spi_mode && expired) |=> spi_sck != $past(spi_sck);
  endproperty
  a_toggle: assert property (p_toggle) else $error("No toggle on expiry");

  property p_done;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_DONE && expired && enabled) |=> event_reg && !ctrl2_reg[CTRL2_STOP_BIT]
        && stat_reg[STAT_STOP_SEEN_BIT];
  endproperty
  a_done: assert property (p_done) else $error("Stop end wrong");

  property p_down;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_DONE && !expired && enabled)
        |=> cnt_reg == ($past(tick_reg) ? $past(cnt_reg) - 1'b1 : $past(cnt_reg));
  endproperty
  a_down: assert property (p_down) else $error("Counter not counting down");

endmodule : scb_top

/* File: tb/scb_bus_model.sv */
// Model of the other masters and slaves sharing the I2C lines
`timescale 1ns/1ps
module scb_bus_model
(
  // Design side
  input wire logic sda_oe,
  input wire logic scl_oe,
  // Bench commands
  input wire logic hold_scl,
  input wire logic pull_sda,
  // Resolved lines
  output logic sda_in,
  output logic scl_in
);
  // Pull-ups: a released line floats high, any party may pull low
  assign sda_in = ~(sda_oe | pull_sda);
  assign scl_in = ~(scl_oe | hold_scl);
endmodule : scb_bus_model

/* File: tb/scb_top_tb.sv */
// Self-checking bench of the stop, collision and baud counter block
`timescale 1ns/1ps
module scb_top_tb;
  import scb_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sda_in;
  logic scl_in;
  logic sda_oe;
  logic scl_oe;
  logic spi_sck;
  logic sda_out;
  logic scl_out;
  logic prev;
  // Another party holds SCL low after the ninth clock
  logic hold_scl = 1'b1;
  logic pull_sda = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  int last;
  int toggles;

  always #25 clk = ~clk;

  scb_top u_scb_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .spi_sck(spi_sck));
  scb_bus_model u_scb_bus_model (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_scl(hold_scl), .pull_sda(pull_sda),
    .sda_in(sda_in), .scl_in(scl_in));

  // ********************************
  // Helpers
  // ********************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic read_check(input logic [2:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp, msg);
  endtask : read_check

  task automatic wait_oe(input logic v, output int cnt);
    cnt = 0;
    while (sda_oe !== v && cnt < 200)
    begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_oe

  task automatic start_stop(input logic [7:0] reload);
    reg_write(ADDR_BAUD_RELOAD, reload);
    reg_write(ADDR_CTRL_ONE, 8'h28);
    reg_write(ADDR_CTRL_TWO, 8'h04);
    wait_oe(1'b1, n);
    check(8'(sda_oe), 8'h01, "stop drives data low");
    check(8'(scl_oe), 8'h00, "clock released");
    check(8'({sda_out, scl_out}), 8'h00, "open drain drives only low");
  endtask : start_stop

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // ********************************
  // Tests
  // ********************************
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++)
      read_check(3'(a), RESET_BYTE, "reset value");
    $display("test reset done");

    start_stop(8'h03);
    read_check(ADDR_BAUD_RELOAD, 8'h03, "reload readback");
    reg_write(ADDR_SHIFT_BUF, 8'h5A);
    read_check(ADDR_CTRL_ONE, 8'hA8, "buffer write refused");
    read_check(ADDR_SHIFT_BUF, 8'h00, "buffer unchanged");
    @(posedge clk) hold_scl <= 1'b0;
    wait_oe(1'b0, n);
    // SCL sampled, one baud period of 2*(3+1) clocks, then the registered enable
    check(8'(n), 8'h0A, "data release after one baud period");
    read_check(ADDR_CTRL_TWO, 8'h04, "request kept until done");
    repeat (12) @(negedge clk);
    read_check(ADDR_STATUS, 8'h10, "stop seen");
    read_check(ADDR_CTRL_TWO, 8'h00, "request cleared");
    read_check(ADDR_FLAGS, 8'h02, "event only");
    reg_write(ADDR_FLAGS, 8'h03);
    read_check(ADDR_FLAGS, 8'h00, "flags cleared");
    @(posedge clk) hold_scl <= 1'b1;
    $display("test clean stop done");

    // Other master pulls SCL low before data goes high
    start_stop(8'h05);
    @(posedge clk) hold_scl <= 1'b0;
    repeat (2) @(posedge clk);
    hold_scl <= 1'b1;
    repeat (3) @(negedge clk);
    check(8'({sda_oe, scl_oe}), 8'h00, "lines released");
    read_check(ADDR_FLAGS, 8'h01, "collision flag");
    read_check(ADDR_CTRL_TWO, 8'h00, "stop aborted");
    reg_write(ADDR_FLAGS, 8'h03);
    $display("test clock collision done");

    // Other master holds SDA low after release
    start_stop(8'h03);
    @(posedge clk) hold_scl <= 1'b0;
    wait_oe(1'b0, n);
    @(posedge clk) pull_sda <= 1'b1;
    repeat (8) @(negedge clk);
    check(8'({sda_oe, scl_oe}), 8'h00, "lines released");
    read_check(ADDR_FLAGS, 8'h01, "collision flag");
    read_check(ADDR_CTRL_TWO, 8'h00, "stop aborted");
    read_check(ADDR_STATUS, 8'h00, "no stop seen");
    @(posedge clk) pull_sda <= 1'b0;
    hold_scl <= 1'b1;
    reg_write(ADDR_FLAGS, 8'h03);
    $display("test data collision done");

    // SPI master clock from the same counter
    reg_write(ADDR_CTRL_ONE, 8'h2A);
    reg_write(ADDR_BAUD_RELOAD, 8'h02);
    check(8'(spi_sck), 8'h00, "clock idle before write");
    reg_write(ADDR_SHIFT_BUF, 8'hC3);
    toggles = 0;
    last = 0;
    prev = spi_sck;
    for (int i = 1; i <= 200; i++)
    begin
      @(negedge clk);
      if (spi_sck !== prev)
      begin
        if (toggles > 0)
          check(8'(i - last), 8'h06, "half period");
        toggles++;
        last = i;
        prev = spi_sck;
      end
    end
    check(8'(toggles), 8'h10, "toggle count");
    check(8'(spi_sck), 8'h00, "clock holds");
    $display("test spi clock done");
    report_and_stop();
  end
endmodule : scb_top_tb
